// File: pfa_defs.svh
// register offsets, enable bit positions and timing constants for the adaptive pwm block
`ifndef PFA_DEFS_SVH
`define PFA_DEFS_SVH
`define PFA_OFS_PERIOD_LIMIT    16'hFE1B
`define PFA_OFS_LL_FREQ         16'hFE1C
`define PFA_OFS_DITHER_PERIOD   16'hFE1D
`define PFA_OFS_SYNC_DIV        16'hFE1E
`define PFA_OFS_LOW_PWR_TH      16'hFE32
`define PFA_OFS_PWR_LOW_PT      16'hFE44
`define PFA_OFS_PWR_HIGH_PT     16'hFE45
`define PFA_OFS_VOUT_LOW_A      16'hFE46
`define PFA_OFS_VOUT_LOW_B      16'hFE47
`define PFA_OFS_VOUT_HIGH_A     16'hFE48
`define PFA_OFS_VOUT_HIGH_B     16'hFE49
`define PFA_OFS_VOUT_TOP        16'hFE4A
`define PFA_OFS_SYNC_DELAY      16'hFE4C
`define PFA_OFS_VLINE_HYST      16'hFE4D
`define PFA_OFS_PWR_HYST        16'hFE4E
`define PFA_OFS_FEATURE_EN      16'hFE4F
`define PFA_EN_DITHER           0
`define PFA_EN_SYNC             1
`define PFA_EN_VOUT_ADAPT       2
`define PFA_EN_LL_FREQ          3
`define PFA_EN_SHED             4
`define PFA_EN_LL_FILTER        5
`define PFA_EN_FEEDFWD          6
`define PFA_REG_RESET           8'h00
`define PFA_SYNC_AVG_CYCLES     3'h7
`define PFA_LL_FILTER_CYCLES    3'h4
`define PFA_PHASE_LOCK_TOL      12'h004
`endif

// File: pfa_pkg.sv
// types shared by the adaptive pwm block
package pfa_pkg;
    typedef struct packed {
        logic        wr;
        logic [15:0] addr;
        logic [7:0]  wdata;
    } pfa_reg_req_t;
    typedef struct packed {
        logic [7:0] vline_rms;
        logic [7:0] power;
        logic       line_cycle;
        logic       soft_start;
        logic       phase_valid;
        logic       phase_pos;
    } pfa_meas_t;
    typedef enum logic [1:0] {
        PFA_BAND_LOW,
        PFA_BAND_HIGH,
        PFA_BAND_SUPER
    } pfa_band_t;
    typedef enum logic [1:0] {
        PFA_SYNC_FREE,
        PFA_SYNC_FREQ,
        PFA_SYNC_PHASE,
        PFA_SYNC_LOCK
    } pfa_sync_t;
endpackage

// File: pfa_setpoint.sv
// load-line output voltage interpolation between two power points
`timescale 1ns/10ps
`default_nettype none
module pfa_setpoint
    import pfa_pkg::*;
(
    // power points
    input  wire logic [7:0] power,
    input  wire logic [7:0] p_low,
    input  wire logic [7:0] p_high,
    // voltage ends
    input  wire logic [7:0] v_light,
    input  wire logic [7:0] v_heavy,
    // result
    output logic      [7:0] v_out
);
    // linear blend; a degenerate span falls back to the light-load end
    function automatic logic [7:0] blend(input logic [7:0] p, input logic [7:0] lo, input logic [7:0] hi,
                                         input logic [7:0] va, input logic [7:0] vb);
        logic [8:0]  span;
        logic [8:0]  pos;
        logic [17:0] prod;
        logic [8:0]  dv;
        span = {1'b0, hi} - {1'b0, lo};
        pos  = {1'b0, p} - {1'b0, lo};
        dv   = (vb >= va) ? ({1'b0, vb} - {1'b0, va}) : ({1'b0, va} - {1'b0, vb});
        prod = {9'h000, pos} * {9'h000, dv};
        if (p <= lo || hi <= lo)
            blend = va;
        else if (p >= hi)
            blend = vb;
        else if (vb >= va)
            blend = va + 8'(prod / {9'h000, span});
        else
            blend = va - 8'(prod / {9'h000, span});
    endfunction

    assign v_out = blend(power, p_low, p_high, v_light, v_heavy);
endmodule
`default_nettype wire

// File: pfa_core.sv
// adaptive pwm control: dither, external sync, load line, light load, shedding, bridgeless drive
`timescale 1ns/10ps
`default_nettype none
`include "pfa_defs.svh"
// Summary of operation
// - dither sweeps period linearly between 87.5% and 112.5% of nominal, for a nominal below 128
// - dither runs only with enable bit 0, sweep rate from dither_period
// - external sync works only with enable bit 1
// - sync period accepted only within 87.5%..112.5% of programmed period
// - average sync period over seven cycles, then align phase
// - when locked, each switching cycle ends a sync_delay count after every n-th sync rising edge
// - lost or out-of-range sync reverts to the limit register period
// - soft start ignores the sync input
// - switching runs at 1, 1/2, 1/3 or 1/4 of sync frequency
// - programmable delay from sync edge to cycle start
// - above super-high line, setpoint is vout_top, with voltage hysteresis, enable bit 2
// - high line: vout_high_a to vout_high_b over the power load line
// - low line: vout_low_a to vout_low_b over the power load line
// - bit 3: light_load_freq below threshold, normal above threshold plus hysteresis
// - bit 5: light filter after four line cycles below threshold
// - normal filter restored at once above threshold plus hysteresis
// - bit 4: shed one pwm output below threshold, restore above plus hysteresis
// - feedforward applied only with enable bit 6
// - positive phase: switch first boost switch, second held on
// - negative phase: switch second boost switch, first held on
// - soft start or bad phase sense: switch both
module pfa_core
    import pfa_pkg::*;
(
    // clock and reset
    input  wire logic       clk,
    input  wire logic       reset_n,
    // register port
    input  wire pfa_reg_req_t reg_req,
    output logic      [7:0] reg_rdata,
    // measurements from the control loop
    input  wire pfa_meas_t  meas,
    input  wire logic [7:0] vline_low_th,
    input  wire logic [7:0] vline_high_th,
    input  wire logic [7:0] vline_super_th,
    input  wire logic       pwm_in,
    // external sync
    input  wire logic       ext_sync_input,
    // outputs
    output logic      [7:0] switch_period,
    output logic            cycle_start,
    output logic      [7:0] vout_setpoint,
    output logic            light_filter_sel,
    output logic            feedfwd_en,
    output logic            sync_locked,
    output logic            first_boost_switch,
    output logic            second_boost_switch,
    output logic            phase2_pwm
);
    logic [1:0] rst_sync_r;
    wire        rst_n = rst_sync_r[1];

    // reset release through two flops
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n)
            rst_sync_r <= 2'b00;
        else
            rst_sync_r <= {rst_sync_r[0], 1'b1};
    end

    // register storage indexed through the reg_index offset decode
    logic [7:0] regs_r [0:15];
    function automatic logic [4:0] reg_index(input logic [15:0] a);
        case (a)
            `PFA_OFS_PERIOD_LIMIT:  reg_index = 5'h00;
            `PFA_OFS_LL_FREQ:       reg_index = 5'h01;
            `PFA_OFS_DITHER_PERIOD: reg_index = 5'h02;
            `PFA_OFS_SYNC_DIV:      reg_index = 5'h03;
            `PFA_OFS_LOW_PWR_TH:    reg_index = 5'h04;
            `PFA_OFS_PWR_LOW_PT:    reg_index = 5'h05;
            `PFA_OFS_PWR_HIGH_PT:   reg_index = 5'h06;
            `PFA_OFS_VOUT_LOW_A:    reg_index = 5'h07;
            `PFA_OFS_VOUT_LOW_B:    reg_index = 5'h08;
            `PFA_OFS_VOUT_HIGH_A:   reg_index = 5'h09;
            `PFA_OFS_VOUT_HIGH_B:   reg_index = 5'h0A;
            `PFA_OFS_VOUT_TOP:      reg_index = 5'h0B;
            `PFA_OFS_SYNC_DELAY:    reg_index = 5'h0C;
            `PFA_OFS_VLINE_HYST:    reg_index = 5'h0D;
            `PFA_OFS_PWR_HYST:      reg_index = 5'h0E;
            `PFA_OFS_FEATURE_EN:    reg_index = 5'h0F;
            default:                reg_index = 5'h10;
        endcase
    endfunction

    wire [4:0] wr_idx = reg_index(reg_req.addr);
    wire [4:0] rd_idx = wr_idx;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < 16; i++)
                regs_r[i] <= `PFA_REG_RESET;
        end else if (reg_req.wr && !wr_idx[4]) begin
            regs_r[wr_idx[3:0]] <= reg_req.wdata;
        end
    end

    // unmapped offsets read as zero
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n)
            reg_rdata <= 8'h00;
        else
            reg_rdata <= rd_idx[4] ? 8'h00 : regs_r[rd_idx[3:0]];
    end

    wire [7:0] period_limit = regs_r[0];
    wire [7:0] ll_freq      = regs_r[1];
    wire [7:0] dither_per   = regs_r[2];
    wire [1:0] sync_div     = regs_r[3][1:0];
    wire [7:0] pwr_th       = regs_r[4];
    wire [7:0] pwr_low_pt   = regs_r[5];
    wire [7:0] pwr_high_pt  = regs_r[6];
    wire [7:0] vout_low_a   = regs_r[7];
    wire [7:0] vout_low_b   = regs_r[8];
    wire [7:0] vout_high_a  = regs_r[9];
    wire [7:0] vout_high_b  = regs_r[10];
    wire [7:0] vout_top     = regs_r[11];
    wire [7:0] sync_delay   = regs_r[12];
    wire [7:0] vline_hyst   = regs_r[13];
    wire [7:0] pwr_hyst     = regs_r[14];
    wire [7:0] feat         = regs_r[15];

    // 87.5% and 112.5% of a period, as p - p/8 and p + p/8
    function automatic logic [8:0] frac_lo(input logic [7:0] p);
        frac_lo = {1'b0, p} - {4'h0, p[7:3]};
    endfunction
    function automatic logic [8:0] frac_hi(input logic [7:0] p);
        frac_hi = {1'b0, p} + {4'h0, p[7:3]};
    endfunction

    // light load frequency with hysteresis on power
    logic light_r;
    wire [8:0] pwr_rise = {1'b0, pwr_th} + {1'b0, pwr_hyst};
    wire       pwr_below = meas.power < pwr_th;
    wire       pwr_above = {1'b0, meas.power} > pwr_rise;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n)
            light_r <= 1'b0;
        else if (pwr_below)
            light_r <= 1'b1;
        else if (pwr_above)
            light_r <= 1'b0;
    end

    wire       ll_freq_on = feat[`PFA_EN_LL_FREQ] && light_r;
    wire [7:0] nominal    = ll_freq_on ? ll_freq : period_limit;

    // dither: triangle sweep of the period offset, stepped by dither_period ticks
    logic [7:0] dith_tick_r;
    logic [4:0] dith_off_r;
    logic       dith_up_r;
    wire        dith_on   = feat[`PFA_EN_DITHER];
    wire        dith_step = dith_on && (dith_tick_r >= dither_per);
    wire [5:0]  dith_span = {nominal[7:3], 1'b0};
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            dith_tick_r <= 8'h00;
            dith_off_r  <= 5'h00;
            dith_up_r   <= 1'b1;
        end else if (!dith_on) begin
            dith_tick_r <= 8'h00;
            dith_off_r  <= 5'h00;
            dith_up_r   <= 1'b1;
        end else if (dith_step) begin
            dith_tick_r <= 8'h00;
            if (dith_up_r && {1'b0, dith_off_r} + 6'h01 >= dith_span)
                dith_up_r <= 1'b0;
            else if (!dith_up_r && dith_off_r <= 5'h01)
                dith_up_r <= 1'b1;
            dith_off_r <= dith_up_r ? dith_off_r + 5'h01 : dith_off_r - 5'h01;
        end else begin
            dith_tick_r <= dith_tick_r + 8'h01;
        end
    end
    // offset spans p/8 either side of nominal while nominal is below 128
    wire [8:0] dith_period = frac_lo(nominal) + {4'h0, dith_off_r};

    // sync edge detection and period measurement
    logic       sync_d_r;
    logic [8:0] sync_cnt_r;
    logic [11:0] sync_acc_r;
    logic [2:0] sync_n_r;
    logic [8:0] sync_avg_r;
    pfa_sync_t  sync_st_r;
    wire        sync_en   = feat[`PFA_EN_SYNC] && !meas.soft_start;
    wire        sync_rise = ext_sync_input && !sync_d_r;
    wire        sync_ok   = sync_cnt_r >= frac_lo(period_limit) &&
                            sync_cnt_r <= frac_hi(period_limit);
    wire        sync_lost = sync_cnt_r > frac_hi(period_limit);

    // division ratio: count sync edges, pass every n-th
    logic [1:0] div_cnt_r;
    wire        div_hit = sync_rise && (div_cnt_r == sync_div);

    // delay from chosen sync edge to cycle start
    logic [7:0] dly_cnt_r;
    logic       dly_run_r;
    wire        dly_fire = dly_run_r && (dly_cnt_r >= sync_delay);

    // internal period counter
    logic [8:0] pwm_cnt_r;
    wire [8:0]  free_period = dith_on ? dith_period : {1'b0, nominal};
    wire        locked      = sync_en && (sync_st_r == PFA_SYNC_LOCK);
    wire        free_end    = (pwm_cnt_r != 9'h000) && (pwm_cnt_r + 9'h001 >= free_period); // floor of two clocks
    wire        cyc_end     = locked ? dly_fire : free_end;
    wire [11:0] phase_err   = {3'h0, ({pwm_cnt_r, 1'b0} < {1'b0, free_period}) ? pwm_cnt_r : free_period - pwm_cnt_r};

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sync_d_r   <= 1'b0;
            sync_cnt_r <= 9'h000;
        end else begin
            sync_d_r   <= ext_sync_input;
            sync_cnt_r <= !sync_en ? 9'h000 : div_hit ? 9'h001 : (sync_lost ? sync_cnt_r : sync_cnt_r + 9'h001);
        end
    end

    // sync acquisition: frequency capture, phase capture, lock
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sync_st_r  <= PFA_SYNC_FREE;
            sync_acc_r <= 12'h000;
            sync_n_r   <= 3'h0;
            sync_avg_r <= 9'h000;
        end else if (!sync_en || sync_lost || (div_hit && !sync_ok && sync_st_r != PFA_SYNC_FREE)) begin
            sync_st_r  <= PFA_SYNC_FREE;
            sync_acc_r <= 12'h000;
            sync_n_r   <= 3'h0;
        end else if (div_hit) begin
            case (sync_st_r)
                PFA_SYNC_FREE: begin
                    sync_st_r <= PFA_SYNC_FREQ;
                end
                PFA_SYNC_FREQ: begin
                    sync_acc_r <= sync_acc_r + {3'h0, sync_cnt_r};
                    sync_n_r   <= sync_n_r + 3'h1;
                    if (sync_n_r + 3'h1 == `PFA_SYNC_AVG_CYCLES) begin
                        sync_avg_r <= 9'((sync_acc_r + {3'h0, sync_cnt_r}) / 12'h007);
                        sync_st_r  <= PFA_SYNC_PHASE;
                    end
                end
                PFA_SYNC_PHASE: begin
                    if (phase_err <= `PFA_PHASE_LOCK_TOL)
                        sync_st_r <= PFA_SYNC_LOCK;
                end
                PFA_SYNC_LOCK: begin
                    sync_st_r <= PFA_SYNC_LOCK;
                end
                default: sync_st_r <= PFA_SYNC_FREE;
            endcase
        end
    end

    // divider and delay counters
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            div_cnt_r <= 2'h0;
            dly_cnt_r <= 8'h00;
            dly_run_r <= 1'b0;
        end else begin
            if (sync_rise)
                div_cnt_r <= div_hit ? 2'h0 : div_cnt_r + 2'h1;
            if (div_hit && locked) begin
                dly_run_r <= 1'b1;
                dly_cnt_r <= 8'h00;
            end else if (dly_fire) begin
                dly_run_r <= 1'b0;
            end else if (dly_run_r) begin
                dly_cnt_r <= dly_cnt_r + 8'h01;
            end
        end
    end

    // pwm period counter; during phase capture restart on sync to pull phase in
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n)
            pwm_cnt_r <= 9'h000;
        else if (cyc_end || (sync_st_r == PFA_SYNC_PHASE && div_hit))
            pwm_cnt_r <= 9'h000;
        else
            pwm_cnt_r <= pwm_cnt_r + 9'h001;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cycle_start   <= 1'b0;
            switch_period <= 8'h00;
        end else begin
            cycle_start   <= cyc_end;
            switch_period <= locked ? 8'(sync_avg_r) : 8'(free_period);
        end
    end

    // line band, sampled once per line cycle with hysteresis at super high line
    pfa_band_t band_r;
    wire [8:0] super_fall = {1'b0, vline_super_th} - {1'b0, vline_hyst};
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n)
            band_r <= PFA_BAND_LOW;
        else if (meas.line_cycle) begin
            if (meas.vline_rms > vline_super_th)
                band_r <= PFA_BAND_SUPER;
            else if (band_r == PFA_BAND_SUPER && {1'b0, meas.vline_rms} > super_fall)
                band_r <= PFA_BAND_SUPER;
            else if (meas.vline_rms > vline_high_th)
                band_r <= PFA_BAND_HIGH;
            else if (meas.vline_rms < vline_low_th)
                band_r <= PFA_BAND_LOW;
        end
    end

    // load-line setpoints for the high and low line bands
    logic [7:0] v_high_line;
    logic [7:0] v_low_line;
    pfa_setpoint u_sp_high (
        .power   (meas.power),
        .p_low   (pwr_low_pt),
        .p_high  (pwr_high_pt),
        .v_light (vout_high_a),
        .v_heavy (vout_high_b),
        .v_out   (v_high_line)
    );
    pfa_setpoint u_sp_low (
        .power   (meas.power),
        .p_low   (pwr_low_pt),
        .p_high  (pwr_high_pt),
        .v_light (vout_low_a),
        .v_heavy (vout_low_b),
        .v_out   (v_low_line)
    );

    // band select; with feature off the output holds vout_top
    wire [7:0] vsp_nxt = !feat[`PFA_EN_VOUT_ADAPT]  ? vout_top :
                         (band_r == PFA_BAND_SUPER) ? vout_top :
                         (band_r == PFA_BAND_HIGH)  ? v_high_line : v_low_line;

    // light filter after four line cycles below threshold, back at once
    logic [2:0] lf_cnt_r;
    logic       lf_r;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            lf_cnt_r <= 3'h0;
            lf_r     <= 1'b0;
        end else if (!feat[`PFA_EN_LL_FILTER] || pwr_above) begin
            lf_cnt_r <= 3'h0;
            lf_r     <= 1'b0;
        end else if (pwr_below && meas.line_cycle && !lf_r) begin
            lf_cnt_r <= lf_cnt_r + 3'h1;
            if (lf_cnt_r + 3'h1 >= `PFA_LL_FILTER_CYCLES)
                lf_r <= 1'b1;
        end
    end

    // shedding and bridgeless drive
    wire shed = feat[`PFA_EN_SHED] && light_r;
    wire both = meas.soft_start || !meas.phase_valid;
    wire q1   = both ? pwm_in : (meas.phase_pos ? pwm_in : 1'b1);
    wire q2   = both ? pwm_in : (meas.phase_pos ? 1'b1 : pwm_in);

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            vout_setpoint       <= 8'h00;
            light_filter_sel    <= 1'b0;
            feedfwd_en          <= 1'b0;
            sync_locked         <= 1'b0;
            first_boost_switch  <= 1'b0;
            second_boost_switch <= 1'b0;
            phase2_pwm          <= 1'b0;
        end else begin
            vout_setpoint       <= vsp_nxt;
            light_filter_sel    <= lf_r;
            feedfwd_en          <= feat[`PFA_EN_FEEDFWD];
            sync_locked         <= locked;
            first_boost_switch  <= q1;
            second_boost_switch <= q2;
            phase2_pwm          <= shed ? 1'b0 : pwm_in;
        end
    end
endmodule
`default_nettype wire

// File: pfa_core_props.sv
// assertion checker for the adaptive pwm block
`timescale 1ns/10ps
`default_nettype none
`include "pfa_defs.svh"
module pfa_core_props
    import pfa_pkg::*;
(
    // clock and reset
    input wire logic         clk,
    input wire logic         reset_n,
    // register port and measurements
    input wire pfa_reg_req_t reg_req,
    input wire logic [7:0]   reg_rdata,
    input wire pfa_meas_t    meas,
    input wire logic         pwm_in,
    // outputs watched
    input wire logic         cycle_start,
    input wire logic         light_filter_sel,
    input wire logic         feedfwd_en,
    input wire logic         sync_locked,
    input wire logic         first_boost_switch,
    input wire logic         second_boost_switch
);
    logic [1:0] up_r;
    logic [7:0] fe_r;
    logic [7:0] th_r;
    logic [7:0] hy_r;
    wire [15:0] a = reg_req.addr;
    wire        rdy = (up_r == 2'h3);
    wire        hi_pwr = {1'b0, meas.power} > ({1'b0, th_r} + {1'b0, hy_r});
    wire        mapped = (a >= 16'hFE1B && a <= 16'hFE1E) || a == 16'hFE32 ||
                         (a >= 16'hFE44 && a <= 16'hFE4A) || (a >= 16'hFE4C && a <= 16'hFE4F);
    // shadow of written registers; outputs are dead for two edges after release
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            up_r <= 2'h0;
            fe_r <= 8'h00;
            th_r <= 8'h00;
            hy_r <= 8'h00;
        end else begin
            up_r <= rdy ? up_r : up_r + 2'h1;
            if (reg_req.wr && a == `PFA_OFS_FEATURE_EN) fe_r <= reg_req.wdata;
            if (reg_req.wr && a == `PFA_OFS_LOW_PWR_TH) th_r <= reg_req.wdata;
            if (reg_req.wr && a == `PFA_OFS_PWR_HYST) hy_r <= reg_req.wdata;
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);
    pos_phase_a: assert property (rdy && meas.phase_valid && meas.phase_pos && !meas.soft_start |=>
        first_boost_switch == $past(pwm_in) && second_boost_switch) else $error("positive phase drive wrong");
    neg_phase_a: assert property (rdy && meas.phase_valid && !meas.phase_pos && !meas.soft_start |=>
        second_boost_switch == $past(pwm_in) && first_boost_switch) else $error("negative phase drive wrong");
    both_switch_a: assert property (rdy && (meas.soft_start || !meas.phase_valid) |=>
        first_boost_switch == $past(pwm_in) && second_boost_switch == $past(pwm_in)) else $error("both not switching");
    ffwd_gate_a: assert property (rdy && fe_r[6] == $past(fe_r[6]) |-> feedfwd_en == fe_r[6])
        else $error("feedforward wrong");
    filt_restore_a: assert property ((rdy && hi_pwr) [*2] |=> !light_filter_sel)
        else $error("normal filter not restored");
    soft_unlock_a: assert property ((rdy && meas.soft_start) [*2] |-> !sync_locked)
        else $error("locked during soft start");
    start_pulse_a: assert property (cycle_start |=> !cycle_start)
        else $error("cycle start too long");
    unmapped_rd_a: assert property (rdy && !mapped |=> reg_rdata == 8'h00)
        else $error("unmapped read not zero");
    cover property (rdy && sync_locked);
    cover property (rdy && $rose(light_filter_sel));
    cover property (rdy && meas.soft_start && pwm_in);
endmodule
bind pfa_core pfa_core_props pfa_core_props_inst (.clk(clk), .reset_n(reset_n), .reg_req(reg_req),
    .reg_rdata(reg_rdata), .meas(meas), .pwm_in(pwm_in), .cycle_start(cycle_start),
    .light_filter_sel(light_filter_sel), .feedfwd_en(feedfwd_en), .sync_locked(sync_locked),
    .first_boost_switch(first_boost_switch), .second_boost_switch(second_boost_switch));
`default_nettype wire

// File: pfa_sync_src.sv
// external sync source model with a programmable period
`timescale 1ns/10ps
`default_nettype none
module pfa_sync_src (
    // clock and control
    input  wire logic       clk,
    input  wire logic       run,
    input  wire logic [7:0] period,
    // sync pin
    output logic            ext_sync
);
    logic [7:0] cnt_r = 8'h00;
    // pin rests low when stopped; two-clock high pulse starts each period
    always @(negedge clk) begin
        cnt_r <= (!run || cnt_r + 8'h01 >= period) ? 8'h00 : cnt_r + 8'h01;
        ext_sync <= run && cnt_r < 8'h02;
    end
endmodule
`default_nettype wire

// File: tb_pfc_pwm_advanced_modes.sv
// testbench for the adaptive pwm block
`timescale 1ns/10ps
`default_nettype none
`include "pfa_defs.svh"
module tb_pfc_pwm_advanced_modes
    import pfa_pkg::*;
;
    logic         clk = 1'b0;
    logic         reset_n = 1'b0;
    pfa_reg_req_t reg_req = '0;
    pfa_meas_t    meas = '0;
    logic         pwm_in = 1'b0;
    logic         run = 1'b0;
    logic [7:0]   per = 8'h30;
    wire          sync_w;
    logic [7:0]   rdata, sper, vsp, mn, mx;
    logic         cs, lfs, ffe, lck, q1, q2, ph2;
    int           n_mismatch = 0;
    int           n_compared = 0;
    int           c;
    logic [15:0]  offs [16] = '{16'hFE1B, 16'hFE1C, 16'hFE1D, 16'hFE1E, 16'hFE32, 16'hFE44, 16'hFE45,
        16'hFE46, 16'hFE47, 16'hFE48, 16'hFE49, 16'hFE4A, 16'hFE4C, 16'hFE4D, 16'hFE4E, 16'hFE4F};
    // rms, power, expected setpoint per band
    logic [7:0]   sp_t [7][3] = '{'{8'h30, 8'h20, 8'h60}, '{8'h30, 8'h90, 8'h70}, '{8'h80, 8'h20, 8'h90},
        '{8'h80, 8'h60, 8'h98}, '{8'hB0, 8'h90, 8'hC0}, '{8'h98, 8'h20, 8'hC0}, '{8'h88, 8'h90, 8'hA0}};
    logic [7:0]   cfg [16] = '{8'h30, 8'h28, 8'h03, 8'h00, 8'h40, 8'h40, 8'h80, 8'h60, 8'h70, 8'h90, 8'hA0, 8'hC0,
        8'h02, 8'h10, 8'h10, 8'h00};
    always #50 clk = ~clk;
    pfa_sync_src pfa_sync_src_inst (.clk(clk), .run(run), .period(per), .ext_sync(sync_w));
    pfa_core pfa_core_inst (.clk(clk), .reset_n(reset_n), .reg_req(reg_req), .reg_rdata(rdata), .meas(meas),
        .vline_low_th(8'h50), .vline_high_th(8'h70), .vline_super_th(8'hA0), .pwm_in(pwm_in),
        .ext_sync_input(sync_w), .switch_period(sper), .cycle_start(cs), .vout_setpoint(vsp),
        .light_filter_sel(lfs), .feedfwd_en(ffe), .sync_locked(lck), .first_boost_switch(q1),
        .second_boost_switch(q2), .phase2_pwm(ph2));
    task automatic finish_test;
        $display("compared %0d mismatches %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
        n_compared++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
        end
    endtask
    // bus tasks start and end at a falling edge
    task automatic wr(input logic [15:0] ad, input logic [7:0] d);
        reg_req = '{1'b1, ad, d};
        @(negedge clk);
        reg_req.wr = 1'b0;
        @(negedge clk);
    endtask
    task automatic rd(input logic [15:0] ad, input logic [7:0] exp);
        reg_req.addr = ad;
        @(negedge clk);
        chk("reg_rdata", exp, rdata);
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic lc;
        meas.line_cycle = 1'b1;
        cyc(1);
        meas.line_cycle = 1'b0;
        cyc(1);
    endtask
    task automatic wait_lock(input logic lv);
        int k = 0;
        while (lck !== lv && k < 4000) begin
            cyc(1);
            k++;
        end
        chk("sync_locked", {7'h0, lv}, {7'h0, lck});
        if (k >= 4000) finish_test();
    endtask
    initial begin
        meas.phase_valid = 1'b1;
        cyc(5);
        reset_n = 1'b1;
        cyc(3);
        for (int i = 0; i < 16; i++) begin
            rd(offs[i], `PFA_REG_RESET);
            wr(offs[i], 8'h10 + 8'(i));
        end
        for (int i = 0; i < 16; i++) rd(offs[i], 8'h10 + 8'(i));
        wr(16'hFE4B, 8'h5A);
        rd(16'hFE4B, 8'h00);
        wr(`PFA_OFS_FEATURE_EN, 8'h40);
        cyc(3);
        chk("feedfwd_en", 8'h01, {7'h0, ffe});
        foreach (offs[i]) wr(offs[i], cfg[i]);
        cyc(3);
        chk("feedfwd_en", 8'h00, {7'h0, ffe});
        for (int i = 0; i < 16; i++) begin
            {meas.soft_start, meas.phase_valid, meas.phase_pos, pwm_in} = 4'(i);
            cyc(2);
            chk("first_sw", {7'h0, meas.phase_valid && !meas.phase_pos && !meas.soft_start || pwm_in}, {7'h0, q1});
            chk("second_sw", {7'h0, meas.phase_valid && meas.phase_pos && !meas.soft_start || pwm_in}, {7'h0, q2});
        end
        meas.soft_start = 1'b0;
        wr(`PFA_OFS_FEATURE_EN, 8'h04);
        for (int i = 0; i < 7; i++) begin
            {meas.vline_rms, meas.power} = {sp_t[i][0], sp_t[i][1]};
            lc();
            cyc(2);
            chk("vout_setpoint", sp_t[i][2], vsp);
        end
        wr(`PFA_OFS_FEATURE_EN, 8'h38);
        {meas.power, pwm_in} = {8'h20, 1'b1};
        repeat (3) lc();
        chk("light_filter", 8'h00, {7'h0, lfs});
        lc();
        cyc(2);
        chk("light_filter", 8'h01, {7'h0, lfs});
        chk("phase2_pwm", 8'h00, {7'h0, ph2});
        chk("switch_period", 8'h28, sper);
        meas.power = 8'h48;
        cyc(3);
        chk("light_filter", 8'h01, {7'h0, lfs});
        meas.power = 8'h60;
        cyc(3);
        chk("light_filter", 8'h00, {7'h0, lfs});
        chk("phase2_pwm", 8'h01, {7'h0, ph2});
        chk("switch_period", 8'h30, sper);
        wr(`PFA_OFS_FEATURE_EN, 8'h01);
        {mn, mx} = 16'hFF00;
        repeat (300) begin
            cyc(1);
            mn = (sper < mn) ? sper : mn;
            mx = (sper > mx) ? sper : mx;
        end
        chk("dither_span", 8'h01, {7'h0, mn == 8'h2A && mx == 8'h36});
        wr(`PFA_OFS_FEATURE_EN, 8'h02);
        for (int d = 0; d < 4; d++) begin
            run = 1'b0;
            wait_lock(1'b0);
            wr(`PFA_OFS_SYNC_DIV, 8'(d));
            {per, run} = {8'(48 / (d + 1)), 1'b1};
            wait_lock(1'b1);
            cyc(72);
            c = 0;
            repeat (480) begin
                cyc(1);
                c += int'(cs);
            end
            chk("cycle_starts", 8'd10, 8'(c));
        end
        per = 8'd90;
        wait_lock(1'b0);
        chk("switch_period", 8'h30, sper);
        {per, meas.soft_start} = {8'd48, 1'b1};
        wr(`PFA_OFS_SYNC_DIV, 8'h00);
        cyc(1000);
        chk("sync_locked", 8'h00, {7'h0, lck});
        meas.soft_start = 1'b0;
        wr(`PFA_OFS_FEATURE_EN, 8'h00);
        cyc(1000);
        chk("sync_locked", 8'h00, {7'h0, lck});
        finish_test();
    end
endmodule
`default_nettype wire
